// file: inc/aem_pkg.sv
// Constants shared by the external memory interface files.
package aem_pkg;
	// Register byte offsets on the register bus.
	localparam logic [7:0] OFS_WAIT_CFG = 8'h04;
	localparam logic [7:0] OFS_REG0_CFG = 8'h10;
	localparam logic [7:0] OFS_REG1_CFG = 8'h14;
	localparam logic [7:0] OFS_IRQ_RAW = 8'h40;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h44;
	localparam logic [7:0] OFS_IRQ_SET = 8'h48;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h4c;
	localparam logic [7:0] OFS_BURST = 8'h5c;
	localparam logic [7:0] OFS_NAND_CTL = 8'h60;
	localparam logic [7:0] OFS_NAND_STS = 8'h64;
	localparam logic [7:0] OFS_PAR0 = 8'h70;
	localparam logic [7:0] OFS_PAR1 = 8'h74;
	localparam logic [7:0] OFS_Q_LOAD = 8'hbc;
	localparam logic [7:0] OFS_Q_W1 = 8'hc0;
	localparam logic [7:0] OFS_Q_W2 = 8'hc4;
	localparam logic [7:0] OFS_Q_W3 = 8'hc8;
	localparam logic [7:0] OFS_Q_W4 = 8'hcc;
	localparam logic [7:0] OFS_ERR_LOC1 = 8'hd0;
	localparam logic [7:0] OFS_ERR_LOC2 = 8'hd4;
	localparam logic [7:0] OFS_ERR_PAT1 = 8'hd8;
	localparam logic [7:0] OFS_ERR_PAT2 = 8'hdc;
	// Region configuration fields; each count field holds cycles minus one.
	localparam int CFG_SS = 31;
	localparam int CFG_EW = 30;
	localparam int CFG_WS_LSB = 26;
	localparam int CFG_WST_LSB = 20;
	localparam int CFG_WH_LSB = 17;
	localparam int CFG_RS_LSB = 13;
	localparam int CFG_RST_LSB = 7;
	localparam int CFG_RH_LSB = 4;
	localparam int CFG_TA_LSB = 2;
	localparam int CFG_ASIZE = 0;
	localparam logic [31:0] CFG_RESET = 32'h3ffffffc;
	// Wait configuration: maximum wait count in the low byte.
	localparam int MAX_WAIT_COUNT_LSB = 0;
	localparam logic [31:0] WAIT_CFG_RESET = 32'h000000ff;
	localparam int WAIT_MULT = 16;
	// Internal cycles from wait release at the pin to output enable high.
	localparam int WAIT_RELEASE_CYC = 4;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] REL_LAST = 2'(WAIT_RELEASE_CYC - SYNC_STAGES - 1);
	// Burst control and NAND control fields.
	localparam int BURST_EN_LSB = 0;
	localparam int BURST_LEN_LSB = 4;
	localparam int NAND_EN_LSB = 0;
	localparam int ECC4_REGION = 4;
	localparam int ECC1_RUN_LSB = 8;
	localparam int ECC4_RUN = 12;
	localparam int IRQ_TIMEOUT = 0;
	// Code sizes.
	localparam int PAR_W = 28;
	localparam int SYM_W = 10;
	localparam int SYM_N = 8;
	localparam int QUAD_W = 80;
	localparam logic [5:0][7:0] COL_MASK = {8'hf0, 8'h0f, 8'hcc, 8'h33, 8'haa, 8'h55};
	localparam logic [79:0] ECC4_TAPS = 80'h0090_0240_0810_2040_0204;
endpackage : aem_pkg

// file: inc/aem_ecc_if.sv
// Signals between the access engine and the error code unit.
`timescale 1ns/100ps
interface aem_ecc_if
	import aem_pkg::*;
();
	logic stb;
	logic [7:0] byte_d;
	logic [SYM_W-1:0] sym;
	logic region;
	logic [1:0] ecc1_run;
	logic [1:0] par_clr;
	logic ecc4_run;
	logic ecc4_region;
	logic ecc4_start;
	logic load_stb;
	logic [SYM_W-1:0] load_d;
	logic [PAR_W-1:0] par0;
	logic [PAR_W-1:0] par1;
	logic [QUAD_W-1:0] quad;
	logic [QUAD_W-1:0] err;
	modport core (output stb, byte_d, sym, region, ecc1_run, par_clr, ecc4_run, ecc4_region,
		ecc4_start, load_stb, load_d, input par0, par1, quad, err);
	modport ecc (input stb, byte_d, sym, region, ecc1_run, par_clr, ecc4_run, ecc4_region,
		ecc4_start, load_stb, load_d, output par0, par1, quad, err);
endinterface : aem_ecc_if

// file: logic/aem_ecc.sv
// Single-bit parity code and four-bit symbol code over NAND data.
`timescale 1ns/100ps
module aem_ecc
	import aem_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	aem_ecc_if.ecc bus
);
	// Whole state of the unit.
	typedef struct packed {
		logic [1:0][PAR_W-1:0] par;
		logic [1:0][10:0] idx;
		logic [QUAD_W-1:0] acc;
		logic [QUAD_W-1:0] load;
	} aem_ecc_type;

	aem_ecc_type s_reg;
	aem_ecc_type s_next;

	// Parity of the bits of a byte that a mask selects.
	function automatic logic odd(input logic [7:0] b, input logic [7:0] m);
		odd = ^(b & m);
	endfunction : odd

	// Accumulates both codes for each data strobe.
	always_comb
	begin
		logic p;
		logic [SYM_W-1:0] sym;
		p = ^bus.byte_d;
		sym = '0;
		s_next = s_reg;
		for (int r = 0; r < 2; r++)
		begin
			if (bus.par_clr[r])
			begin
				s_next.par[r] = '0;
				s_next.idx[r] = '0;
			end
			else if (bus.stb && bus.region == r[0] && bus.ecc1_run[r])
			begin
				// Row parities split by each bit of the byte index.
				for (int k = 0; k < 11; k++)
				begin
					if (s_reg.idx[r][k])
						s_next.par[r][7 + 2 * k] = s_reg.par[r][7 + 2 * k] ^ p; // see (R7)
					else
						s_next.par[r][6 + 2 * k] = s_reg.par[r][6 + 2 * k] ^ p;
				end
				// Column parities inside the byte.
				for (int c = 0; c < 6; c++)
					s_next.par[r][c] = s_reg.par[r][c] ^ odd(bus.byte_d, COL_MASK[c]);
				s_next.idx[r] = s_reg.idx[r] + 11'h1;
			end
		end
		if (bus.ecc4_start)
		begin
			s_next.acc = '0;
			s_next.load = '0;
		end
		else
		begin
			// Each symbol lane runs its own feedback polynomial.
			if (bus.stb && bus.ecc4_run && bus.region == bus.ecc4_region)
			begin
				for (int i = 0; i < SYM_N; i++)
				begin
					sym = s_reg.acc[i * SYM_W +: SYM_W];
					s_next.acc[i * SYM_W +: SYM_W] = {sym[8:0], ^(sym & ECC4_TAPS[i * SYM_W +: SYM_W])}
						^ bus.sym; // see (R7)
				end
			end
			// Stored code from the flash shifts in one symbol per write.
			if (bus.load_stb)
				s_next.load = {s_reg.load[QUAD_W-SYM_W-1:0], bus.load_d};
		end
	end

	// Registers the state.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign bus.par0 = s_reg.par[0];
	assign bus.par1 = s_reg.par[1];
	assign bus.quad = s_reg.acc;
	// Syndrome feeds the error location and pattern words.
	assign bus.err = s_reg.acc ^ s_reg.load; // see (R9)
endmodule : aem_ecc

// file: logic/aem_top.sv
// External asynchronous memory interface: registers, access engine and pins.
// How it works
// (R1) Two chip-select regions, sixteen megabytes each.
// (R2) Data bus eight or sixteen bits wide.
// (R3) Burst flash always uses sixteen-bit bus.
// (R4) Burst flash: async access, linear burst reads.
// (R5) Never issue wrapping burst reads.
// (R6) Each region has its own timings.
// (R7) Compute one-bit and four-bit NAND codes.
// (R8) One parity register per region.
// (R9) Error locations and patterns in four registers.
// (R10) One configuration register per region.
// (R11) Raw status, mask, mask-set, mask-clear ports.
// (R12) Read lasts setup+strobe+hold plus three.
// (R13) Bank select valid setup+1 before enable.
// (R14) Bank select held hold+1 after enable.
// (R15) Memory raises wait four cycles early.
// (R16) Memory keeps wait levels two cycles.
// (R17) Burst data taken on memory clock rise.
// (R18) Count ranges: turn 4, setup 16, strobe 64, hold 8.
// (R19) Write lasts sum plus turnaround plus four.
// (R20) Output enable rises four after wait release.
// (R21) Wait beyond maximum count ends by timeout.
// (R22) Select strobe: chip select during strobe only.
// (R23) Turnaround idle on direction or region change.
// (R24) Timeout sets raw bit; mask gates interrupt.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module aem_top
	import aem_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic xfer_req,
	input wire logic xfer_write,
	input wire logic xfer_region,
	input wire logic [23:0] xfer_addr,
	input wire logic [15:0] xfer_wdata,
	output logic xfer_busy,
	output logic xfer_done,
	output logic xfer_rvalid,
	output logic [15:0] xfer_rdata,
	input wire logic mem_hold_off_in,
	input wire logic [15:0] mem_data_io_in,
	output logic [15:0] mem_data_io_out,
	output logic mem_data_io_oe_n,
	output logic [1:0] mem_chip_select_n,
	output logic mem_output_enable_n,
	output logic mem_write_enable_n,
	output logic [1:0] mem_bank_select,
	output logic [21:0] mem_addr_out,
	output logic mem_burst_clock,
	output logic mem_addr_valid_n,
	output logic irq
);
	// Access phases, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SETUP = 8'h02,
		ST_STROBE = 8'h04,
		ST_WAIT = 8'h08,
		ST_HOLD = 8'h10,
		ST_DONE = 8'h20,
		ST_TURN = 8'h40,
		ST_BURST = 8'h80
	} aem_state_type;

	// Whole state of the block.
	typedef struct packed {
		logic waitreq; // Bus wait, high between answers.
		logic [31:0] rdata; // Bus read data.
		logic [31:0] wait_cfg; // Wait configuration.
		logic [31:0] cfg0; // Region 0 timings.
		logic [31:0] cfg1; // Region 1 timings.
		logic [31:0] burst_ctl; // Burst flash control.
		logic [31:0] nand_ctl; // NAND control.
		logic raw; // Sticky timeout status.
		logic mask; // Timeout interrupt enable.
		logic irq; // Interrupt pin.
		aem_state_type st; // Access phase.
		logic [12:0] cnt; // Phase down counter.
		logic [1:0] rel; // Cycles since wait release.
		logic pend; // Access waits behind turnaround.
		logic we; // Access is a write.
		logic region; // Access region.
		logic burst; // Access is a burst read.
		logic [15:0] wdata; // Write data.
		logic last_valid; // An access has finished.
		logic last_we; // Direction of the last access.
		logic last_region; // Region of the last access.
		logic hold_s1; // Wait synchroniser, first stage.
		logic hold_s2; // Wait synchroniser, second stage.
		logic [15:0] d_s1; // Data synchroniser, first stage.
		logic [15:0] d_s2; // Data synchroniser, second stage.
		logic [15:0] rd; // Last read word.
		logic done; // Access end pulse.
		logic rvalid; // Read word pulse.
		logic busy; // Engine not idle.
		logic [1:0] cs_n; // Chip selects.
		logic oe_n; // Output enable.
		logic we_n; // Write enable.
		logic adv_n; // Address valid.
		logic bclk; // Burst clock.
		logic d_oe_n; // Data drive enable.
		logic [21:0] a; // Address pins.
		logic [1:0] ba; // Bank select pins.
		logic [3:0] words; // Burst words left after the next one.
		logic ecc_stb; // Data word for the codes.
		logic [15:0] ecc_d; // Its value.
		logic [1:0] par_clr; // Parity clear pulses.
		logic ecc4_start; // Symbol code restart.
		logic load_stb; // Stored symbol write.
		logic [9:0] load_d; // Stored symbol.
	} aem_core_type;

	localparam aem_core_type CORE_RESET = '{
		waitreq: 1'b1, rdata: 32'h0, wait_cfg: WAIT_CFG_RESET, cfg0: CFG_RESET,
		cfg1: CFG_RESET, burst_ctl: 32'h0, nand_ctl: 32'h0, raw: 1'b0, mask: 1'b0,
		irq: 1'b0, st: ST_IDLE, cnt: 13'h0, rel: 2'h0, pend: 1'b0, we: 1'b0,
		region: 1'b0, burst: 1'b0, wdata: 16'h0, last_valid: 1'b0, last_we: 1'b0,
		last_region: 1'b0, hold_s1: 1'b0, hold_s2: 1'b0, d_s1: 16'h0, d_s2: 16'h0,
		rd: 16'h0, done: 1'b0, rvalid: 1'b0, busy: 1'b0, cs_n: 2'h3, oe_n: 1'b1,
		we_n: 1'b1, adv_n: 1'b1, bclk: 1'b0, d_oe_n: 1'b1, a: 22'h0, ba: 2'h0,
		words: 4'h0, ecc_stb: 1'b0, ecc_d: 16'h0, par_clr: 2'h0, ecc4_start: 1'b0,
		load_stb: 1'b0, load_d: 10'h0};

	aem_core_type s_reg;
	aem_core_type s_next;
	logic [31:0] cur_cfg; // Timings of the region in use.
	logic [31:0] req_cfg; // Timings of the requested region.

	aem_ecc_if ecc_bus();

	// Picks the configuration of one region.
	function automatic logic [31:0] pick_cfg(input logic r, input logic [31:0] c0, input logic [31:0] c1);
		pick_cfg = r ? c1 : c0; // see (R6)
	endfunction : pick_cfg

	// Setup phase length minus one: the setup count plus one cycle.
	function automatic logic [12:0] setup_cnt(input logic we, input logic [31:0] c);
		setup_cnt = we ? 13'(c[CFG_WS_LSB +: 4]) + 13'h1 : 13'(c[CFG_RS_LSB +: 4]) + 13'h1;
	endfunction : setup_cnt

	// Packs two code symbols into one register word.
	function automatic logic [31:0] sym_word(input logic [QUAD_W-1:0] v, input int k);
		sym_word = {6'h0, v[(2 * k + 1) * SYM_W +: SYM_W], 6'h0, v[2 * k * SYM_W +: SYM_W]};
	endfunction : sym_word

	assign cur_cfg = pick_cfg(s_reg.region, s_reg.cfg0, s_reg.cfg1);
	assign req_cfg = pick_cfg(xfer_region, s_reg.cfg0, s_reg.cfg1);

	// Register bus, access engine and pin levels.
	always_comb
	begin
		logic to_hold;
		logic strobe;
		logic act;
		logic [31:0] nxt_cfg; // Timings of the region of the next phase.
		to_hold = 1'b0;
		strobe = 1'b0;
		act = 1'b0;
		nxt_cfg = 32'h0;
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.ecc_stb = 1'b0;
		s_next.par_clr = 2'h0;
		s_next.ecc4_start = 1'b0;
		s_next.load_stb = 1'b0;
		// Pin inputs pass two flip-flops.
		s_next.hold_s1 = mem_hold_off_in;
		s_next.hold_s2 = s_reg.hold_s1;
		s_next.d_s1 = mem_data_io_in;
		s_next.d_s2 = s_reg.d_s1;
		// Every bus request is answered in the following cycle.
		s_next.waitreq = 1'b1;
		if ((avs_read || avs_write) && s_reg.waitreq)
		begin
			s_next.waitreq = 1'b0;
			s_next.rdata = 32'h0;
			if (avs_read)
			begin
				case (avs_address)
					OFS_WAIT_CFG: s_next.rdata = s_reg.wait_cfg;
					OFS_REG0_CFG: s_next.rdata = s_reg.cfg0; // see (R10)
					OFS_REG1_CFG: s_next.rdata = s_reg.cfg1; // see (R10)
					OFS_IRQ_RAW: s_next.rdata = {31'h0, s_reg.raw}; // see (R11)
					OFS_IRQ_MSK: s_next.rdata = {31'h0, s_reg.raw & s_reg.mask}; // see (R11)
					OFS_IRQ_SET: s_next.rdata = {31'h0, s_reg.mask};
					OFS_IRQ_CLR: s_next.rdata = {31'h0, s_reg.mask};
					OFS_BURST: s_next.rdata = s_reg.burst_ctl;
					OFS_NAND_CTL: s_next.rdata = s_reg.nand_ctl;
					OFS_NAND_STS: s_next.rdata = {23'h0, s_reg.busy, 7'h0, s_reg.hold_s2};
					OFS_PAR0:
					begin
						// Reading a parity word clears it.
						s_next.rdata = {4'h0, ecc_bus.par0}; // see (R8)
						s_next.par_clr[0] = 1'b1;
					end
					OFS_PAR1:
					begin
						s_next.rdata = {4'h0, ecc_bus.par1}; // see (R8)
						s_next.par_clr[1] = 1'b1;
					end
					OFS_Q_W1: s_next.rdata = sym_word(ecc_bus.quad, 0);
					OFS_Q_W2: s_next.rdata = sym_word(ecc_bus.quad, 1);
					OFS_Q_W3: s_next.rdata = sym_word(ecc_bus.quad, 2);
					OFS_Q_W4: s_next.rdata = sym_word(ecc_bus.quad, 3);
					OFS_ERR_LOC1: s_next.rdata = sym_word(ecc_bus.err, 0); // see (R9)
					OFS_ERR_LOC2: s_next.rdata = sym_word(ecc_bus.err, 1); // see (R9)
					OFS_ERR_PAT1: s_next.rdata = sym_word(ecc_bus.err, 2); // see (R9)
					OFS_ERR_PAT2: s_next.rdata = sym_word(ecc_bus.err, 3); // see (R9)
					default: s_next.rdata = 32'h0;
				endcase
			end
			else
			begin
				case (avs_address)
					OFS_WAIT_CFG: s_next.wait_cfg = avs_writedata;
					OFS_REG0_CFG: s_next.cfg0 = avs_writedata;
					OFS_REG1_CFG: s_next.cfg1 = avs_writedata;
					OFS_IRQ_RAW: s_next.raw = s_reg.raw & ~avs_writedata[IRQ_TIMEOUT]; // see (R11)
					OFS_IRQ_SET: s_next.mask = s_reg.mask | avs_writedata[IRQ_TIMEOUT]; // see (R11)
					OFS_IRQ_CLR: s_next.mask = s_reg.mask & ~avs_writedata[IRQ_TIMEOUT]; // see (R11)
					OFS_BURST: s_next.burst_ctl = avs_writedata;
					OFS_NAND_CTL:
					begin
						// Starting a code clears what it held.
						s_next.nand_ctl = avs_writedata;
						s_next.par_clr = avs_writedata[ECC1_RUN_LSB +: 2] & ~s_reg.nand_ctl[ECC1_RUN_LSB +: 2];
						s_next.ecc4_start = avs_writedata[ECC4_RUN] & ~s_reg.nand_ctl[ECC4_RUN];
					end
					OFS_Q_LOAD:
					begin
						s_next.load_stb = 1'b1;
						s_next.load_d = avs_writedata[9:0];
					end
					default: s_next.load_stb = 1'b0;
				endcase
			end
		end
		// Access engine; one internal cycle is one clock.
		case (s_reg.st)
			ST_IDLE:
			begin
				if (xfer_req)
				begin
					s_next.we = xfer_write;
					s_next.region = xfer_region;
					s_next.wdata = xfer_wdata;
					// Only linear bursts exist; reads of a burst region burst.
					s_next.burst = !xfer_write && s_reg.burst_ctl[BURST_EN_LSB + 32'(xfer_region)]; // see (R4) (R5)
					// Sixteen-bit parts take a word address.
					if (req_cfg[CFG_ASIZE] || s_next.burst) // see (R2) (R3)
						{s_next.a, s_next.ba} = {xfer_addr[23:1], 1'b0}; // see (R1)
					else
						{s_next.a, s_next.ba} = xfer_addr; // see (R1)
					if (s_reg.last_valid && !s_reg.last_we && (xfer_write || xfer_region != s_reg.last_region))
					begin
						s_next.st = ST_TURN; // see (R23)
						s_next.pend = 1'b1;
						s_next.cnt = 13'(req_cfg[CFG_TA_LSB +: 2]);
					end
					else if (s_next.burst)
					begin
						s_next.st = ST_BURST;
						s_next.words = s_reg.burst_ctl[BURST_LEN_LSB +: 4];
						s_next.adv_n = 1'b0;
					end
					else
					begin
						s_next.st = ST_SETUP;
						s_next.cnt = setup_cnt(xfer_write, req_cfg); // see (R13)
					end
				end
			end
			ST_SETUP:
			begin
				if (s_reg.cnt == 13'h0)
				begin
					s_next.st = ST_STROBE;
					s_next.cnt = s_reg.we ? 13'(cur_cfg[CFG_WST_LSB +: 6]) : 13'(cur_cfg[CFG_RST_LSB +: 6]); // see (R18)
				end
				else
					s_next.cnt = s_reg.cnt - 13'h1;
			end
			ST_STROBE:
			begin
				if (s_reg.cnt != 13'h0)
					s_next.cnt = s_reg.cnt - 13'h1;
				else if (cur_cfg[CFG_EW] && s_reg.hold_s2) // see (R15)
				begin
					// Wait seen by the end of strobe stretches it.
					s_next.st = ST_WAIT;
					s_next.rel = 2'h0;
					s_next.cnt = 13'((32'(s_reg.wait_cfg[MAX_WAIT_COUNT_LSB +: 8]) + 32'h1) * WAIT_MULT - 1); // see (R21)
				end
				else
					to_hold = 1'b1;
			end
			ST_WAIT:
			begin
				if (s_reg.hold_s2)
					s_next.rel = 2'h0;
				else if (s_reg.rel == REL_LAST)
					to_hold = 1'b1; // see (R20)
				else
					s_next.rel = s_reg.rel + 2'h1;
				if (s_reg.cnt == 13'h0)
				begin
					to_hold = 1'b1; // see (R21)
					s_next.raw = 1'b1; // see (R24)
				end
				else
					s_next.cnt = s_reg.cnt - 13'h1;
			end
			ST_HOLD:
			begin
				if (s_reg.cnt == 13'h0)
					s_next.st = ST_DONE; // see (R12)
				else
					s_next.cnt = s_reg.cnt - 13'h1;
			end
			ST_DONE:
			begin
				s_next.rvalid = !s_reg.we && !s_reg.burst;
				s_next.last_valid = 1'b1;
				s_next.last_we = s_reg.we;
				s_next.last_region = s_reg.region;
				if (s_reg.we)
				begin
					// A write always closes with turnaround plus one.
					s_next.st = ST_TURN; // see (R19)
					s_next.pend = 1'b0;
					s_next.cnt = 13'(cur_cfg[CFG_TA_LSB +: 2]) + 13'h1;
				end
				else
					s_next.st = ST_IDLE;
			end
			ST_TURN:
			begin
				if (s_reg.cnt != 13'h0)
					s_next.cnt = s_reg.cnt - 13'h1;
				else if (!s_reg.pend)
					s_next.st = ST_IDLE;
				else if (s_reg.burst)
				begin
					s_next.st = ST_BURST;
					s_next.words = s_reg.burst_ctl[BURST_LEN_LSB +: 4];
					s_next.adv_n = 1'b0;
				end
				else
				begin
					s_next.st = ST_SETUP;
					s_next.cnt = setup_cnt(s_reg.we, cur_cfg);
				end
			end
			ST_BURST:
			begin
				// Memory clock is the clock divided by two.
				s_next.bclk = !s_reg.bclk;
				if (!s_reg.bclk)
				begin
					if (!s_reg.adv_n)
						s_next.adv_n = 1'b1;
					else
					begin
						s_next.rd = s_reg.d_s2; // see (R17)
						s_next.rvalid = 1'b1;
						s_next.ecc_stb = 1'b1;
						s_next.ecc_d = s_reg.d_s2;
						if (s_reg.words == 4'h0)
							s_next.st = ST_DONE;
						else
							s_next.words = s_reg.words - 4'h1;
					end
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// Strobe end: take read data and enter hold.
		if (to_hold)
		begin
			s_next.st = ST_HOLD;
			s_next.cnt = s_reg.we ? 13'(cur_cfg[CFG_WH_LSB +: 3]) + 13'h1 : 13'(cur_cfg[CFG_RH_LSB +: 3]) + 13'h1; // see (R14)
			s_next.ecc_stb = 1'b1;
			s_next.ecc_d = s_reg.we ? s_reg.wdata : s_reg.d_s2;
			if (!s_reg.we)
				s_next.rd = s_reg.d_s2;
		end
		// Pin levels follow the next phase.
		strobe = s_next.st == ST_STROBE || s_next.st == ST_WAIT;
		act = strobe || s_next.st == ST_SETUP || s_next.st == ST_HOLD || s_next.st == ST_BURST;
		s_next.cs_n = 2'h3;
		nxt_cfg = pick_cfg(s_next.region, s_reg.cfg0, s_reg.cfg1);
		if (strobe || (act && !nxt_cfg[CFG_SS]))
			s_next.cs_n[s_next.region] = 1'b0; // see (R22)
		s_next.oe_n = !((strobe && !s_next.we) || s_next.st == ST_BURST);
		s_next.we_n = !(strobe && s_next.we);
		s_next.d_oe_n = !(act && s_next.we);
		if (s_next.st != ST_BURST)
		begin
			s_next.adv_n = 1'b1;
			s_next.bclk = 1'b0;
		end
		s_next.busy = s_next.st != ST_IDLE;
		s_next.done = s_next.st == ST_DONE;
		s_next.irq = s_next.raw & s_next.mask; // see (R24)
	end

	// Registers the state.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			s_reg <= CORE_RESET;
		else
			s_reg <= s_next;
	end

	// Code unit sees NAND words only.
	assign ecc_bus.stb = s_reg.ecc_stb && s_reg.nand_ctl[NAND_EN_LSB + 32'(s_reg.region)]; // see (R7)
	assign ecc_bus.byte_d = s_reg.ecc_d[7:0];
	assign ecc_bus.sym = s_reg.ecc_d[9:0];
	assign ecc_bus.region = s_reg.region;
	assign ecc_bus.ecc1_run = s_reg.nand_ctl[ECC1_RUN_LSB +: 2];
	assign ecc_bus.par_clr = s_reg.par_clr;
	assign ecc_bus.ecc4_run = s_reg.nand_ctl[ECC4_RUN];
	assign ecc_bus.ecc4_region = s_reg.nand_ctl[ECC4_REGION];
	assign ecc_bus.ecc4_start = s_reg.ecc4_start;
	assign ecc_bus.load_stb = s_reg.load_stb;
	assign ecc_bus.load_d = s_reg.load_d;

	aem_ecc u_ecc (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus(ecc_bus.ecc)
	);

	assign avs_readdata = s_reg.rdata;
	assign avs_waitrequest = s_reg.waitreq;
	assign xfer_busy = s_reg.busy;
	assign xfer_done = s_reg.done;
	assign xfer_rvalid = s_reg.rvalid;
	assign xfer_rdata = s_reg.rd;
	assign mem_data_io_out = s_reg.wdata;
	assign mem_data_io_oe_n = s_reg.d_oe_n;
	assign mem_chip_select_n = s_reg.cs_n;
	assign mem_output_enable_n = s_reg.oe_n;
	assign mem_write_enable_n = s_reg.we_n;
	assign mem_bank_select = s_reg.ba;
	assign mem_addr_out = s_reg.a;
	assign mem_burst_clock = s_reg.bclk;
	assign mem_addr_valid_n = s_reg.adv_n;
	assign irq = s_reg.irq;
endmodule : aem_top

// file: test/aem_top_checker.sv
// Port assertions for the external memory interface.
`timescale 1ns/100ps
module aem_top_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic xfer_req,
	input wire logic xfer_busy,
	input wire logic xfer_done,
	input wire logic mem_data_io_oe_n,
	input wire logic [1:0] mem_chip_select_n,
	input wire logic mem_output_enable_n,
	input wire logic mem_write_enable_n,
	input wire logic mem_burst_clock,
	input wire logic mem_addr_valid_n
);
	// All checks run on the one clock and rest while reset is low.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late ack");
	AST_TAKE: assert property (xfer_req && !xfer_busy |=> xfer_busy)
		else $error("request not taken");
	AST_DONE: assert property (xfer_done |=> !xfer_done)
		else $error("done too long");
	AST_ONE_CS: assert property (mem_chip_select_n != 2'b00)
		else $error("both selects low");
	AST_STROBES: assert property (mem_output_enable_n || mem_write_enable_n)
		else $error("two strobes");
	// Output enable of an async read falls only if busy was already high two cycles earlier.
	AST_OE_SETUP: assert property ($fell(mem_output_enable_n) && mem_addr_valid_n |-> $past(xfer_busy, 2))
		else $error("no setup");
	AST_DRIVE: assert property (!mem_data_io_oe_n |-> mem_output_enable_n)
		else $error("drive in read");
	AST_BCLK: assert property (!xfer_busy |-> !mem_burst_clock)
		else $error("clock when idle");
endmodule : aem_top_checker
bind aem_top aem_top_checker i_aem_top_checker (.ref_clk, .nrst, .avs_read, .avs_write, .avs_waitrequest,
	.xfer_req, .xfer_busy, .xfer_done, .mem_data_io_oe_n, .mem_chip_select_n, .mem_output_enable_n,
	.mem_write_enable_n, .mem_burst_clock, .mem_addr_valid_n);

// file: test/aem_mem_model.sv
// Behavioural memory on the far side of the pins.
`timescale 1ns/100ps
module aem_mem_model #(
	parameter logic [15:0] WORD = 16'ha5c3
) (
	input wire logic ref_clk,
	input wire logic [1:0] mem_chip_select_n,
	input wire logic hold_cmd,
	output logic mem_hold_off_in = 1'b0,
	output logic [15:0] mem_data_io_in = 16'h0000
);
	// A deselected bus toggles so that no stale word can pass for good data.
	always @(posedge ref_clk)
	begin
		if (mem_chip_select_n != 2'b11)
			mem_data_io_in <= WORD;
		else
			mem_data_io_in <= ~mem_data_io_in;
		mem_hold_off_in <= hold_cmd;
	end
endmodule : aem_mem_model

// file: test/tb_aem_top.sv
// Self-checking bench for the external memory interface.
`timescale 1ns/100ps
module tb_aem_top
	import aem_pkg::*;
;
	localparam logic [31:0] CFGV = 32'h00200101;
	logic ref_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, xfer_req = 0, xfer_write = 0, xfer_region = 0;
	logic hold_cmd = 0, avs_waitrequest, xfer_busy, xfer_done, mem_hold_off_in, mem_data_io_oe_n;
	logic mem_output_enable_n, mem_write_enable_n, mem_burst_clock, irq, xfer_rvalid;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [23:0] xfer_addr = 24'h000000;
	logic [15:0] xfer_wdata = 16'h1234, xfer_rdata, mem_data_io_in;
	logic [1:0] mem_chip_select_n;
	int n_fail = 0, num_checks = 0, n, m, n_low, n_rv;
	// Register rows: offset, write flag, write data, expected read.
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} aem_row_type;
	aem_row_type rows [8] = '{'{OFS_WAIT_CFG, 0, 0, 32'hff}, '{OFS_REG0_CFG, 0, 0, 32'h3ffffffc},
		'{OFS_REG1_CFG, 0, 0, 32'h3ffffffc}, '{OFS_REG1_CFG, 1, 32'h12345678, 32'h12345678},
		'{8'h80, 1, 5, 0}, '{OFS_IRQ_SET, 1, 1, 1}, '{OFS_IRQ_CLR, 1, 1, 0}, '{OFS_IRQ_RAW, 0, 0, 0}};
	always #25 ref_clk = ~ref_clk;
	aem_top i_aem_top (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .xfer_req, .xfer_write, .xfer_region, .xfer_addr, .xfer_wdata, .xfer_busy, .xfer_done,
		.xfer_rvalid, .xfer_rdata, .mem_hold_off_in, .mem_data_io_in, .mem_data_io_out(), .mem_data_io_oe_n,
		.mem_chip_select_n, .mem_output_enable_n, .mem_write_enable_n, .mem_bank_select(), .mem_addr_out(),
		.mem_burst_clock, .mem_addr_valid_n(), .irq);
	aem_mem_model i_aem_mem_model (.ref_clk, .mem_chip_select_n, .hold_cmd, .mem_hold_off_in, .mem_data_io_in);
	// Compares one value and counts it.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	// One register bus cycle, held until waitrequest is seen low.
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask : bus
	// One access; counts busy cycles, busy cycles up to done and strobe cycles.
	task xfer(input logic w, input logic r);
		@(posedge ref_clk);
		xfer_req <= 1;
		xfer_write <= w;
		xfer_region <= r;
		@(posedge ref_clk);
		xfer_req <= 0;
		n = 0;
		m = 0;
		n_low = 0;
		n_rv = 0;
		repeat (300)
		begin
			@(posedge ref_clk);
			m += (xfer_busy === 1'b1);
			n_low += w ? (mem_write_enable_n === 1'b0) : (mem_output_enable_n === 1'b0);
			n_rv += (xfer_rvalid === 1'b1);
			if (n == 0 && xfer_done === 1'b1)
				n = m;
		end
	endtask : xfer
	// Prints the verdict and stops.
	task end_sim;
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Watchdog against a hung handshake.
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		end_sim;
	end
	// Reset, register rows, timed accesses, wait release, timeout interrupt and a mid-run reset.
	initial
	begin
		repeat (8) @(posedge ref_clk);
		chk(avs_waitrequest, 1);
		chk(mem_chip_select_n, 2'b11);
		nrst <= 1;
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus(rows[i].a, 1, rows[i].d);
			bus(rows[i].a, 0, 0);
			chk(q, rows[i].e);
		end
		bus(OFS_REG0_CFG, 1, CFGV);
		xfer(0, 0);
		chk(n, 8);
		chk(n_low, 3);
		chk(n_rv, 1);
		chk(xfer_rdata, 16'ha5c3);
		// A write after a read first waits one turnaround cycle.
		xfer(1, 0);
		chk(m, 11);
		chk(n_low, 3);
		chk(n_rv, 0);
		bus(OFS_REG1_CFG, 1, CFGV | 32'h40000000);
		// Wait pin drops after the edge 21; output enable rises four cycles later.
		hold_cmd <= 1;
		fork
			xfer(0, 1);
			begin
				repeat (20) @(posedge ref_clk);
				hold_cmd <= 0;
			end
		join
		chk(n_low, 21);
		bus(OFS_WAIT_CFG, 1, 0);
		hold_cmd <= 1;
		xfer(0, 1);
		hold_cmd <= 0;
		bus(OFS_IRQ_RAW, 0, 0);
		chk(q, 1);
		chk(irq, 0);
		bus(OFS_IRQ_SET, 1, 1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1);
		bus(OFS_IRQ_RAW, 1, 1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 0);
		// A mid-run reset brings the region timings back.
		nrst <= 0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		bus(OFS_REG0_CFG, 0, 0);
		chk(q, CFG_RESET);
		end_sim;
	end
endmodule : tb_aem_top
